// >>> unbalance_pkg.sv
// package of constants, register map and types for the current unbalance block
package unbalance_pkg;
    localparam int          MAG_W          = 16;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          MS_DIV         = 1000;
    localparam int          CYC_PER_MS     = CLK_HZ / MS_DIV;
    localparam int          PCT_FULL       = 100;
    localparam int          PCT_SUFFICIENT = 10;
    localparam int          PCT_FAULT      = 150;
    localparam int          HYST_NUM       = 95;
    localparam int          HYST_DEN       = 100;
    localparam logic [6:0]  THR_MIN        = 7'h0a;
    localparam logic [6:0]  THR_MAX        = 7'h5a;
    localparam logic [6:0]  THR_DEFAULT    = 7'h32;
    localparam logic [15:0] DLY_MIN        = 16'h0064;
    localparam logic [15:0] DLY_MAX        = 16'hea60;
    localparam logic [15:0] DLY_DEFAULT    = 16'h03e8;
    localparam logic [MAG_W-1:0] RATED_DEFAULT = 16'h03e8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] THR_OFS     = 8'h04;
    localparam logic [7:0] DLY_OFS     = 8'h08;
    localparam logic [7:0] RATED_OFS   = 8'h0c;
    localparam logic [7:0] STATUS_OFS  = 8'h10;

    // control bit positions
    localparam int CTRL_ENABLE_BIT     = 0;
    localparam int CTRL_START_ONLY_BIT = 1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [MAG_W-1:0] ph1;
        logic [MAG_W-1:0] ph2;
        logic [MAG_W-1:0] ph3;
    } phase_mag_t;

    typedef struct packed {
        logic       enable;
        logic       start_only;
        logic [6:0] thr_pct;
        logic [15:0] delay_ms;
        logic [MAG_W-1:0] rated;
    } settings_t;
endpackage

// >>> unbalance_eval.sv
// combinational spread and range evaluation of three phase magnitudes
`timescale 1ns/1ns
`default_nettype none
module unbalance_eval
    import unbalance_pkg::*;
#(
    parameter int W = MAG_W
) (
    input  wire phase_mag_t mags,
    input  wire logic [6:0] thr_pct,
    input  wire logic [W-1:0] rated,
    output logic            spread_pick,
    output logic            spread_hold,
    output logic            max_current_sufficient,
    output logic            max_current_not_fault
);
    wire [W-1:0]  max12  = (mags.ph1 > mags.ph2) ? mags.ph1 : mags.ph2;
    wire [W-1:0]  min12  = (mags.ph1 > mags.ph2) ? mags.ph2 : mags.ph1;
    wire [W-1:0]  imax   = (max12 > mags.ph3) ? max12 : mags.ph3; // [R1]
    wire [W-1:0]  imin   = (min12 < mags.ph3) ? min12 : mags.ph3; // [R1]
    wire [W-1:0]  diff   = imax - imin;
    // cross-multiplied to avoid a divider: diff*100 > thr*max
    wire [W+13:0] lhs    = {14'h0000, diff} * (W+14)'(PCT_FULL);
    wire [W+13:0] rhs    = {14'h0000, imax} * (W+14)'(thr_pct);
    wire [W+20:0] lhs_h  = {7'h00, lhs} * 21'(HYST_DEN);
    wire [W+20:0] rhs_h  = {7'h00, rhs} * 21'(HYST_NUM);
    wire [W+7:0]  max_p  = {8'h00, imax} * (W+8)'(PCT_FULL);
    wire [W+7:0]  lo_lim = {8'h00, rated} * (W+8)'(PCT_SUFFICIENT);
    wire [W+7:0]  hi_lim = {8'h00, rated} * (W+8)'(PCT_FAULT);

    assign spread_pick            = lhs > rhs;     // [R2]
    assign spread_hold            = lhs_h >= rhs_h; // [R12]
    assign max_current_sufficient = max_p > lo_lim; // [R4]
    assign max_current_not_fault  = max_p < hi_lim; // [R4]
endmodule
`default_nettype wire

// >>> current_unbalance_function.sv
// current unbalance protection decision block with AHB-Lite settings
// Operation
// R1 - pick largest and smallest of three phase magnitudes each evaluation
// R2 - flag when max-min spread as percent of max exceeds threshold
// R3 - start asserted when spread flag set and max current conditions met
// R4 - start only while max above 10% and below 150% of rated
// R5 - operation setting off suppresses start and trip
// R6 - active block input keeps start and trip inactive
// R7 - trip after start persists for delay, only if trips enabled
// R8 - upstream stage supplies magnitudes; no Fourier computed here
// R9 - threshold setting 10 to 90 percent, default 50
// R10 - delay setting 100 to 60000 ms, default 1000
// R11 - start-only option gives start but never trip; default false
// R12 - start drops only when spread falls below 0.95 of pickup
// R13 - timer cleared and trip dropped on start loss, block or disable
`timescale 1ns/1ns
`default_nettype none
module current_unbalance_function
    import unbalance_pkg::*;
#(
    parameter int                W          = MAG_W,
    parameter int                CYC_MS     = CYC_PER_MS
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            clk_en,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic [31:0]          hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    input  wire logic [W-1:0]    phase1_current_magnitude,
    input  wire logic [W-1:0]    phase2_current_magnitude,
    input  wire logic [W-1:0]    phase3_current_magnitude,
    input  wire logic            block_in,
    output logic                 general_start_out,
    output logic                 general_trip_out
);
    // settings registers
    logic              enable_reg;
    logic              start_only_reg;
    logic [6:0]        thr_reg;
    logic [15:0]       dly_reg;
    logic [W-1:0]      rated_reg;
    // bus address phase capture
    logic              wr_pend_reg;
    logic [7:0]        addr_reg;
    // protection state
    logic              start_reg;
    logic              trip_reg;
    logic [15:0]       ms_cnt_reg;
    logic [31:0]       cyc_cnt_reg;

    phase_mag_t        mags;
    logic              spread_pick;
    logic              spread_hold;
    logic              max_current_sufficient;
    logic              max_current_not_fault;

    // magnitudes arrive ready-made from the upstream Fourier stage [R8]
    assign mags = '{ph1: phase1_current_magnitude,
                    ph2: phase2_current_magnitude,
                    ph3: phase3_current_magnitude};

    unbalance_eval #(.W(W)) u_eval (
        .mags                   (mags),
        .thr_pct                (thr_reg),
        .rated                  (rated_reg),
        .spread_pick            (spread_pick),
        .spread_hold            (spread_hold),
        .max_current_sufficient (max_current_sufficient),
        .max_current_not_fault  (max_current_not_fault)
    );

    // ---- AHB-Lite slave: zero wait state, always OKAY ----
    wire        bus_take  = hsel && hready && htrans == HTRANS_NONSEQ;
    wire        rd_take   = bus_take && !hwrite;
    wire        wr_take   = bus_take && hwrite;
    wire [7:0]  rd_addr   = haddr[7:0];
    wire        rd_ctrl   = rd_addr == CTRL_OFS;
    wire        rd_thr    = rd_addr == THR_OFS;
    wire        rd_dly    = rd_addr == DLY_OFS;
    wire        rd_rate   = rd_addr == RATED_OFS;
    wire        rd_stat   = rd_addr == STATUS_OFS;
    wire [31:0] ctrl_word = {30'h0000_0000, start_only_reg, enable_reg};
    wire [31:0] stat_word = {26'h000_0000, max_current_not_fault,
                             max_current_sufficient, spread_pick,
                             trip_reg, start_reg, block_in};
    wire [31:0] rd_mux =
        rd_ctrl ? ctrl_word :
        rd_thr  ? {25'h000_0000, thr_reg} :
        rd_dly  ? {16'h0000, dly_reg} :
        rd_rate ? {{(32-W){1'b0}}, rated_reg} :
        rd_stat ? stat_word : 32'h0000_0000;

    // out-of-range settings are clamped so the block never runs outside spec
    wire [6:0]  thr_in  = hwdata[6:0];
    wire        thr_low = thr_in < THR_MIN;
    wire        thr_hi  = |hwdata[31:7] || thr_in > THR_MAX;
    wire [6:0]  thr_cl  = thr_hi  ? THR_MAX :
                          thr_low ? THR_MIN : thr_in;              // [R9]
    wire [15:0] dly_in  = hwdata[15:0];
    wire        dly_low = dly_in < DLY_MIN;
    wire        dly_hi  = |hwdata[31:16] || dly_in > DLY_MAX;
    wire [15:0] dly_cl  = dly_hi  ? DLY_MAX :
                          dly_low ? DLY_MIN : dly_in;              // [R10]
    wire        wr_ctrl = wr_pend_reg && addr_reg == CTRL_OFS;
    wire        wr_thr  = wr_pend_reg && addr_reg == THR_OFS;
    wire        wr_dly  = wr_pend_reg && addr_reg == DLY_OFS;
    wire        wr_rate = wr_pend_reg && addr_reg == RATED_OFS;

    // address kept only on a taken transfer so idle cycles cannot move it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else if (clk_en) begin
            wr_pend_reg <= wr_take;
            if (bus_take) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    // read data stands until the next read is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && rd_take) begin
            hrdata <= rd_mux;
        end
    end

    // defaults: function off, start-only false [R9] [R10] [R11]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg     <= 1'b0;
            start_only_reg <= 1'b0;
            thr_reg        <= THR_DEFAULT;
            dly_reg        <= DLY_DEFAULT;
            rated_reg      <= RATED_DEFAULT;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                enable_reg     <= hwdata[CTRL_ENABLE_BIT];
                start_only_reg <= hwdata[CTRL_START_ONLY_BIT];
            end
            if (wr_thr) begin
                thr_reg <= thr_cl;
            end
            if (wr_dly) begin
                dly_reg <= dly_cl;
            end
            if (wr_rate) begin
                rated_reg <= hwdata[W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---- decision logic ----
    wire allowed   = enable_reg && !block_in;                      // [R5] [R6]
    wire range_ok  = max_current_sufficient && max_current_not_fault; // [R4]
    // pickup needs the full threshold; hold needs only 0.95 of it
    wire spread_ok = start_reg ? spread_hold : spread_pick;       // [R12]
    wire start_next = allowed && range_ok && spread_ok;           // [R3]
    wire ms_tick    = cyc_cnt_reg == 32'(CYC_MS - 1);
    wire delay_done = ms_cnt_reg >= dly_reg;
    wire trip_en    = !start_only_reg;                            // [R11]
    wire ms_step    = ms_tick && !delay_done;
    wire trip_next  = start_next && trip_en && delay_done;        // [R7] [R11]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_reg <= 1'b0;
            trip_reg  <= 1'b0;
        end else if (clk_en) begin
            start_reg <= start_next;
            trip_reg  <= trip_next;
        end
    end

    // prescaler restarts with the ms count so every ms step is a full one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_cnt_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (!start_next || ms_tick) begin
                cyc_cnt_reg <= 32'h0000_0000;
            end else begin
                cyc_cnt_reg <= cyc_cnt_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_reg <= 16'h0000;
        end else if (clk_en) begin
            if (!start_next) begin
                // timer restarts from zero on any drop [R13]
                ms_cnt_reg <= 16'h0000;
            end else if (ms_step) begin
                ms_cnt_reg <= ms_cnt_reg + 16'h0001; // [R7]
            end
        end
    end

    assign general_start_out = start_reg;
    assign general_trip_out  = trip_reg;
endmodule
`default_nettype wire

// >>> unbalance_assertions.sv
// port-level assertions for the current unbalance block
`timescale 1ns/1ns
`default_nettype none
module unbalance_assertions
    import unbalance_pkg::*;
#(
    parameter int W = MAG_W
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hreadyout,
    input  wire logic         hresp,
    input  wire logic [W-1:0] phase1_current_magnitude,
    input  wire logic [W-1:0] phase2_current_magnitude,
    input  wire logic [W-1:0] phase3_current_magnitude,
    input  wire logic         block_in,
    input  wire logic         general_start_out,
    input  wire logic         general_trip_out
);
    wire logic [W-1:0] a = phase1_current_magnitude;
    wire logic [W-1:0] b = phase2_current_magnitude;
    wire logic [W-1:0] c = phase3_current_magnitude;
    wire logic         st = general_start_out;
    wire logic         tr = general_trip_out;
    wire logic [W-1:0] mx = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
    wire logic [W-1:0] mn = (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
    // range uses the reset rating: the bench writes it back after its register test
    wire logic in_rng = mx * 100 > RATED_DEFAULT * 10
                     && mx * 100 < RATED_DEFAULT * 150;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence quiet_s;
        !tr [*8];
    endsequence
    block_quiet_a: assert property (block_in |=> !st && !tr)
        else $error("outputs active while blocked");
    trip_needs_start_a: assert property (tr |-> st)
        else $error("trip without start");
    trip_after_start_a: assert property ($rose(tr) |-> $past(st))
        else $error("trip rose without prior start");
    start_range_a: assert property (st |-> $past(in_rng))
        else $error("start outside current range");
    start_spread_a: assert property (st |-> $past(mx > mn))
        else $error("start with no spread");
    start_cause_a: assert property ($rose(st) |-> $past(!block_in))
        else $error("start rose while blocked");
    trip_clear_a: assert property ($fell(st) |-> quiet_s)
        else $error("trip after start loss");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
endmodule
bind current_unbalance_function unbalance_assertions #(.W(W)) chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .phase1_current_magnitude(phase1_current_magnitude),
    .phase2_current_magnitude(phase2_current_magnitude),
    .phase3_current_magnitude(phase3_current_magnitude),
    .block_in(block_in), .general_start_out(general_start_out),
    .general_trip_out(general_trip_out));
`default_nettype wire

// >>> mag_source.sv
// upstream magnitude stage model feeding the unbalance block
`timescale 1ns/1ns
`default_nettype none
module mag_source
    import unbalance_pkg::*;
(
    input  wire logic        hclk,
    input  wire phase_mag_t  mags,
    output logic [MAG_W-1:0] m1,
    output logic [MAG_W-1:0] m2,
    output logic [MAG_W-1:0] m3
);
    // finished magnitudes, one set per evaluation, no raw samples
    always_ff @(posedge hclk) begin
        {m1, m2, m3} <= mags;
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the current unbalance block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import unbalance_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, blk = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]  htrans = 0;
    logic        hrdy, hresp, st, tr;
    logic [15:0] m1, m2, m3;
    phase_mag_t  mags = '0;
    int          n_errors = 0, checks_done = 0, k, t;
    logic [7:0]  ta[7] = '{THR_OFS, THR_OFS, DLY_OFS, DLY_OFS, 8'h14,
        RATED_OFS, RATED_OFS};
    logic [31:0] tw[7] = '{5, 95, 50, 32'h0000_ffff, 32'h1234_5678,
        32'h0001_07d0, RATED_DEFAULT};
    logic [31:0] te[7] = '{THR_MIN, THR_MAX, DLY_MIN, DLY_MAX, 0,
        32'h0000_07d0, RATED_DEFAULT};
    phase_mag_t  rm[5] = '{{16'h0064, 16'h000a, 16'h000a},
        {16'h0065, 16'h000a, 16'h000a}, {16'h05dc, 16'h0064, 16'h0064},
        {16'h000a, 16'h000a, 16'h00c8}, {16'h05db, 16'h0064, 16'h0064}};
    logic        re[5] = '{0, 1, 0, 1, 1};
    always #25 hclk = ~hclk;
    mag_source src (.hclk(hclk), .mags(mags), .m1(m1), .m2(m2), .m3(m3));
    current_unbalance_function #(.CYC_MS(2)) DUT (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .phase1_current_magnitude(m1),
        .phase2_current_magnitude(m2), .phase3_current_magnitude(m3),
        .block_in(blk), .general_start_out(st), .general_trip_out(tr));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one transfer: address phase, then data phase, both held to hready
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        hsel <= 1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 0, 0);
        check(q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // bounded wait, the watchdog still guards the whole run
    task automatic wait_trip();
        t = 0;
        while (tr !== 1'b1 && t < 400) begin
            @(posedge hclk);
            t++;
        end
    endtask
    initial begin
        #(20000 * 50);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        cyc(5);
        hresetn <= 1;
        cyc(1);
        rd(CTRL_OFS, 0);
        rd(THR_OFS, THR_DEFAULT);
        rd(DLY_OFS, DLY_DEFAULT);
        for (k = 0; k < 7; k++) begin
            bus(ta[k], 1, tw[k]);
            rd(ta[k], te[k]);
        end
        $display("test registers done");
        bus(DLY_OFS, 1, DLY_MIN);
        bus(THR_OFS, 1, THR_DEFAULT);
        mags <= {16'h03e8, 16'h0190, 16'h0190};
        cyc(8);
        check(st, 0);
        bus(CTRL_OFS, 1, 1);
        cyc(3);
        check(st, 1);
        wait_trip();
        // delay counts from onset, which is about three cycles back
        check(t inside {[188:200]}, 1);
        rd(STATUS_OFS, 32'h0000_003e);
        mags <= {16'h03e8, 16'h0208, 16'h0208};
        cyc(4);
        check({st, tr}, 2'b11);
        mags <= {16'h03e8, 16'h0212, 16'h0212};
        cyc(4);
        check({st, tr}, 2'b00);
        mags <= {16'h03e8, 16'h0208, 16'h0208};
        cyc(4);
        check(st, 0);
        $display("test delay and hysteresis done");
        for (k = 0; k < 5; k++) begin
            mags <= rm[k];
            cyc(4);
            check(st, re[k]);
        end
        wait_trip();
        check(tr, 1);
        blk <= 1;
        cyc(2);
        check({st, tr}, 2'b00);
        rd(STATUS_OFS, 32'h0000_0039);
        blk <= 0;
        cyc(100);
        check({st, tr}, 2'b10);
        bus(CTRL_OFS, 1, 3);
        cyc(300);
        check({st, tr}, 2'b10);
        bus(CTRL_OFS, 1, 0);
        cyc(3);
        check(st, 0);
        $display("test range block and modes done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
